/* File: hdl/cpis_top.sv */
// Functional notes
// R1: cpu interrupts come only from block end, scan change or program instruction.
// R2: block interrupt flag is bit 0 of the block control byte.
// R3: scan change sets line status bit 11 (second byte bit 3).
// R4: scan change with scan interrupt enable sets first status byte bit 1.
// R5: scan interrupt leaves the block unfinished; block status stays zero.
// R6: program interrupt instruction sets first byte bit 0 and interrupts.
// R7: that instruction clears the whole first status byte first.
// R8: host reads line status bytes directly.
// R9: get next block copies line status into block status, then clears it.
// R10: completed block gets status bit 3, plus bit 1 if it interrupted.
// R11: host reads block status by next-status and plain status reads.
// R12: every interrupt is offered; cpu accepts or rejects it.
// R13: a rejected interrupt is deferred until the retry signal.
// R14: each channel keeps its own deferred count, 0 to 3.
// R15: the deferred count saturates at three and never wraps.
// R16: on retry, channels are visited in turn, one offer per nonzero count.
// R17: an accepted resubmission decrements that count by exactly one.
// R18: one scanning pass per retry assertion.
// R19: scan cpu interrupt wins over scan program start.
// R20: channel program reaches block area only through its fixed operations.
// R21: no path lets one line reach another line's table.
//
// Our own choices: the register addresses and the APB register port.
`include "cpis_regs.svh"

module cpis_top #(
    parameter int NUM_CHAN = 4,
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk, // processor clock
    input wire logic arst_n, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire cpis_pkg::cpis_evt_s evt, // engine event
    input wire logic retry_in, // bus retry pin
    input wire logic irq_ack, // cpu accepted
    input wire logic irq_nak, // cpu rejected
    output logic irq_req, // interrupt offered
    output logic [$clog2(NUM_CHAN)-1:0] irq_chan, // offering channel
    output logic prog_start, // start program pulse
    output logic [$clog2(NUM_CHAN)-1:0] prog_chan // channel to start
);
    // channel index width and last index of a retry pass
    localparam int CW = $clog2(NUM_CHAN);
    localparam logic [CW-1:0] LAST = CW'(NUM_CHAN - 1);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // events carry an eight bit channel number
    if (NUM_CHAN < 2 || NUM_CHAN > 256) begin : g_bad_chan
        $error("NUM_CHAN must lie in 2..256");
    end
    // every channel window must be reachable through paddr
    if (ADDR_W < CW + `CPIS_CHAN_LSB || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W too narrow for the channel windows");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        cpis_pkg::cpis_chan_s [NUM_CHAN-1:0] ch;
        cpis_pkg::cpis_irq_e st;
        logic [CW-1:0] cur;
        logic from_retry;
        logic in_pass;
        logic [CW-1:0] ptr;
        logic retry_seen;
        // retry synchroniser and edge flop
        logic rs1;
        logic rs2;
        logic rs3;
        // registered copies of the outputs
        logic irq_req;
        logic [CW-1:0] irq_chan;
        logic prog_start;
        logic [CW-1:0] prog_chan;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cpis_state_s;

    cpis_state_s s;
    cpis_state_s next_s;

    // ----------------------------------------
    // address decode, shared by both phases
    // ----------------------------------------
    logic [CW-1:0] a_chan;
    logic [3:0] a_off;
    logic a_bad;
    logic [ADDR_W-1:0] a_hi;

    // upper bits beyond the last window make the access unmapped
    always_comb begin
        a_chan = paddr[`CPIS_CHAN_LSB +: CW];
        a_off = paddr[3:0];
        a_hi = paddr >> (`CPIS_CHAN_LSB + CW);
        a_bad = (a_hi != '0) ||
            (int'(a_chan) >= NUM_CHAN) ||
            (a_off[1:0] != 2'h0);
    end

    // ----------------------------------------
    // per channel request flags
    // ----------------------------------------
    logic [NUM_CHAN-1:0] pend_vec;
    logic [NUM_CHAN-1:0] owed_vec;

    // flattened once, so the sequencer reads plain bit vectors
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
        assign pend_vec[g] = s.ch[g].pend;
        assign owed_vec[g] = (s.ch[g].dcnt != 2'h0);
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic found;
        logic [CW-1:0] pick;
        logic [CW-1:0] ec;
        next_s = s;
        found = 1'b0;
        pick = '0;
        ec = '0;
        next_s.prog_start = 1'b0;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;

        // ----------------------------------------
        // retry pin: two flops, then edge detect on the second
        // ----------------------------------------
        next_s.rs1 = retry_in;
        next_s.rs2 = s.rs1;
        next_s.rs3 = s.rs2;

        // lowest channel with a fresh interrupt waiting
        // fresh work first: a retry storm must not starve new events
        for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (pend_vec[i]) begin
                found = 1'b1;
                pick = CW'(i);
            end
        end

        // ----------------------------------------
        // interrupt offer sequencer
        // ----------------------------------------
        unique case (s.st)
            cpis_pkg::CPIS_IDLE: begin
                if (found) begin
                    // R12: fresh offers ignore earlier rejections
                    next_s.ch[pick].pend = 1'b0;
                    next_s.cur = pick;
                    next_s.from_retry = 1'b0;
                    next_s.irq_req = 1'b1;
                    next_s.irq_chan = pick;
                    next_s.st = cpis_pkg::CPIS_OFFER;
                end else if (s.in_pass) begin
                    // R16: visit in turn, offer where count nonzero
                    if (owed_vec[s.ptr]) begin
                        next_s.cur = s.ptr;
                        next_s.from_retry = 1'b1;
                        next_s.irq_req = 1'b1;
                        next_s.irq_chan = s.ptr;
                        next_s.st = cpis_pkg::CPIS_OFFER;
                    end else if (s.ptr == LAST) begin
                        next_s.in_pass = 1'b0;
                    end else begin
                        next_s.ptr = s.ptr + 1'b1;
                    end
                end else if (s.retry_seen) begin
                    // R13: deferred offers wait for the retry signal
                    next_s.retry_seen = 1'b0;
                    next_s.in_pass = 1'b1;
                    next_s.ptr = '0;
                end
            end
            cpis_pkg::CPIS_OFFER: begin
                if (irq_ack || irq_nak) begin
                    next_s.irq_req = 1'b0;
                    next_s.st = cpis_pkg::CPIS_IDLE;
                    if (s.from_retry) begin
                        // each channel gets one offer per pass
                        if (s.ptr == LAST) begin
                            next_s.in_pass = 1'b0;
                        end else begin
                            next_s.ptr = s.ptr + 1'b1;
                        end
                    end
                end
                if (irq_ack && s.from_retry) begin
                    // R17: accepted resubmission, count minus one
                    // never zero here: the pass skips empty channels
                    next_s.ch[s.cur].dcnt = s.ch[s.cur].dcnt - 2'h1;
                end
                // ack wins when both answers are high
                if (irq_nak && !irq_ack && !s.from_retry) begin
                    // R14: per channel count of deferred offers
                    // R15: saturate, never wrap
                    if (s.ch[s.cur].dcnt != `CPIS_DCNT_MAX) begin
                        next_s.ch[s.cur].dcnt = s.ch[s.cur].dcnt + 2'h1;
                    end
                end
            end
        endcase

        // R18: one pass noted per rising retry
        // after the sequencer, so a fresh edge beats its same-cycle clear
        if (s.rs2 && !s.rs3) begin
            next_s.retry_seen = 1'b1;
        end

        // ----------------------------------------
        // apb first access edge: latch read data and ready
        // ----------------------------------------
        if (psel && penable && !s.pready) begin
            // read data frozen here; the completion edge only has side effects
            next_s.pready = 1'b1;
            next_s.pslverr = a_bad;
            next_s.prdata = 32'h0000_0000;
            if (!a_bad && !pwrite) begin
                unique case (a_off)
                    `CPIS_OFF_LSTAT: begin
                        // R8: line status read directly
                        next_s.prdata = {16'h0000, s.ch[a_chan].lstat};
                    end
                    `CPIS_OFF_BLK, `CPIS_OFF_NEXT: begin
                        // R11: block status returned to host
                        next_s.prdata = {16'h0000, s.ch[a_chan].blk};
                    end
                    `CPIS_OFF_CTRL: begin
                        next_s.prdata[`CPIS_CTL_IBIT] = s.ch[a_chan].ibit;
                        next_s.prdata[`CPIS_CTL_SCAN_CPU] = s.ch[a_chan].scan_cpu;
                        next_s.prdata[`CPIS_CTL_SCAN_PGM] = s.ch[a_chan].scan_pgm;
                        next_s.prdata[`CPIS_CTL_DCNT_LSB +: 2] = s.ch[a_chan].dcnt;
                    end
                    default: begin
                        next_s.prdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // ----------------------------------------
        // apb completion edge: writes and read side effects
        // ----------------------------------------
        if (psel && penable && s.pready && !a_bad) begin
            if (pwrite && a_off == `CPIS_OFF_CTRL) begin
                // R2: block interrupt flag from control bit 0
                next_s.ch[a_chan].ibit = pwdata[`CPIS_CTL_IBIT];
                next_s.ch[a_chan].scan_cpu = pwdata[`CPIS_CTL_SCAN_CPU];
                next_s.ch[a_chan].scan_pgm = pwdata[`CPIS_CTL_SCAN_PGM];
            end
            if (!pwrite && a_off == `CPIS_OFF_NEXT) begin
                // R11: next-status read hands the block over
                next_s.ch[a_chan].blk = `CPIS_BLK_RST;
            end
        end

        // ----------------------------------------
        // engine events last, so a set beats a same-cycle clear
        // ----------------------------------------
        // R20: engine reaches block state only via these events
        // R21: an event touches only its own channel's table
        if (evt.valid && int'(evt.chan) < NUM_CHAN) begin
            ec = evt.chan[CW-1:0];
            // R1: only these three causes raise an interrupt
            unique case (evt.kind)
                cpis_pkg::CPIS_EV_SCAN: begin
                    // R3: status change flag
                    next_s.ch[ec].lstat[`CPIS_LSTAT_DS_CHANGE] = 1'b1;
                    // R19: cpu interrupt wins over program start
                    if (s.ch[ec].scan_cpu) begin
                        // R4: scan interrupt flag
                        next_s.ch[ec].lstat[`CPIS_LSTAT_SCAN_INT] = 1'b1;
                        // R5: block left running, status untouched
                        next_s.ch[ec].pend = 1'b1;
                    end else if (s.ch[ec].scan_pgm) begin
                        // start pulse only while the cpu path is off
                        next_s.prog_start = 1'b1;
                        next_s.prog_chan = ec;
                    end
                end
                cpis_pkg::CPIS_EV_PGM_IRQ: begin
                    // R7: whole first byte cleared, then flag set
                    // R6: program interrupt flag and offer
                    next_s.ch[ec].lstat[7:0] = `CPIS_PGM_IRQ_BYTE1;
                    next_s.ch[ec].pend = 1'b1;
                end
                cpis_pkg::CPIS_EV_NEXT_BLK: begin
                    // R9: copy line status, then clear it
                    next_s.ch[ec].blk = s.ch[ec].lstat;
                    next_s.ch[ec].lstat = `CPIS_LSTAT_RST;
                    // R10: done bit, interrupt bit when flagged
                    next_s.ch[ec].blk[`CPIS_BLK_DONE] = 1'b1;
                    if (s.ch[ec].ibit) begin
                        next_s.ch[ec].blk[`CPIS_BLK_INT] = 1'b1;
                        next_s.ch[ec].pend = 1'b1;
                    end
                end
                default: begin
                    next_s.prog_chan = s.prog_chan;
                end
            endcase
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // one register for all state, so reset clears everything at once
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // outputs, all from the state register
    // ----------------------------------------
    // apb answer
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;

    // interrupt offer and program start
    assign irq_req = s.irq_req;
    assign irq_chan = s.irq_chan;
    assign prog_start = s.prog_start;
    assign prog_chan = s.prog_chan;

endmodule // cpis_top

/* File: hdl/cpis_regs.svh */
`ifndef CPIS_REGS_SVH
`define CPIS_REGS_SVH
// ----------------------------------------
// register offsets inside one channel window
// ----------------------------------------
`define CPIS_OFF_LSTAT 4'h0
`define CPIS_OFF_BLK 4'h4
`define CPIS_OFF_NEXT 4'h8
`define CPIS_OFF_CTRL 4'hc
// byte address bit where the channel number starts
`define CPIS_CHAN_LSB 4
// ----------------------------------------
// field positions
// ----------------------------------------
`define CPIS_LSTAT_PGM_INT 0
`define CPIS_LSTAT_SCAN_INT 1
`define CPIS_LSTAT_DS_CHANGE 11
`define CPIS_BLK_INT 1
`define CPIS_BLK_DONE 3
`define CPIS_CTL_IBIT 0
`define CPIS_CTL_SCAN_CPU 10
`define CPIS_CTL_SCAN_PGM 11
`define CPIS_CTL_DCNT_LSB 16
// ----------------------------------------
// values
// ----------------------------------------
`define CPIS_DCNT_MAX 2'h3
`define CPIS_PGM_IRQ_BYTE1 8'h01
`define CPIS_LSTAT_RST 16'h0000
`define CPIS_BLK_RST 16'h0000
`endif

/* File: hdl/cpis_pkg.sv */
package cpis_pkg;
    // ----------------------------------------
    // events from the channel-program engine
    // ----------------------------------------
    typedef enum logic [1:0] {
        CPIS_EV_SCAN,
        CPIS_EV_PGM_IRQ,
        CPIS_EV_NEXT_BLK
    } cpis_evt_e;

    typedef struct packed {
        logic valid;
        cpis_evt_e kind;
        logic [7:0] chan;
    } cpis_evt_s;

    // ----------------------------------------
    // per channel state and offer sequencer
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] lstat;
        logic [15:0] blk;
        logic ibit;
        logic scan_cpu;
        logic scan_pgm;
        logic [1:0] dcnt;
        logic pend;
    } cpis_chan_s;

    typedef enum logic {
        CPIS_IDLE,
        CPIS_OFFER
    } cpis_irq_e;
endpackage

/* File: tb/cpis_host.sv */
// ----------------------------------------
// host cpu answering interrupt offers
// ----------------------------------------
module cpis_host (
    input wire logic sys_clk, // processor clock
    input wire logic arst_n, // async reset, low
    input wire logic irq_req, // offer from block
    input wire logic accept, // ack when high, else nak
    input wire logic [3:0] lag, // cycles before answering
    output logic irq_ack, // offer accepted
    output logic irq_nak // offer rejected
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    logic done;
    // one answer per offer; done stops a double answer while the offer drops
    // accept or reject
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 4'h0;
            done <= 1'h0;
            irq_ack <= 1'h0;
            irq_nak <= 1'h0;
        end else begin
            irq_ack <= 1'h0;
            irq_nak <= 1'h0;
            if (irq_req !== 1'h1) begin
                cnt <= 4'h0;
                done <= 1'h0;
            end else if (!done && cnt == lag) begin
                irq_ack <= accept;
                irq_nak <= !accept;
                done <= 1'h1;
            end else if (!done) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule // cpis_host

/* File: tb/cpis_chk.sv */
module cpis_chk #(
    parameter int NUM_CHAN = 4,
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk, // processor clock
    input wire logic arst_n, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire cpis_pkg::cpis_evt_s evt, // engine event
    input wire logic irq_ack, // cpu accepted
    input wire logic irq_nak, // cpu rejected
    input wire logic irq_req, // interrupt offered
    input wire logic [$clog2(NUM_CHAN)-1:0] irq_chan, // offering channel
    input wire logic prog_start // start program pulse
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // engine events seen as scan or program interrupt
    wire scan_ev = evt.valid && evt.kind == cpis_pkg::CPIS_EV_SCAN;
    wire pgm_irq_ev = evt.valid && evt.kind == cpis_pkg::CPIS_EV_PGM_IRQ &&
        evt.chan < NUM_CHAN;
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb ready missing after wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("apb ready longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("apb ready without access");
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("apb error without ready or with data");
    offer_hold_a: assert property (
        irq_req && !irq_ack && !irq_nak |=> irq_req && $stable(irq_chan))
        else $error("offer dropped or changed unanswered");
    answer_drop_a: assert property (irq_req && (irq_ack || irq_nak) |=> !irq_req)
        else $error("offer held after answer");
    pgm_offer_a: assert property (pgm_irq_ev && !irq_req |-> ##[1:3] irq_req)
        else $error("program interrupt not offered");
    start_cause_a: assert property (
        prog_start |-> $past(scan_ev) || $past(scan_ev, 2))
        else $error("program start without scan");
endmodule // cpis_chk

bind cpis_top cpis_chk #(.NUM_CHAN(NUM_CHAN), .ADDR_W(ADDR_W)) i_cpis_chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .irq_ack(irq_ack), .irq_nak(irq_nak), .irq_req(irq_req),
    .irq_chan(irq_chan), .prog_start(prog_start)
);

/* File: tb/cpis_top_test.sv */
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end

module cpis_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, err, accept;
    logic retry_in, irq_ack, irq_nak, irq_req, prog_start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] lag;
    logic [1:0] irq_chan, prog_chan, last_chan;
    cpis_pkg::cpis_evt_s evt;
    int bad_count, num_checks, starts, offers;

    cpis_top i_cpis_top (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
        .retry_in(retry_in), .irq_ack(irq_ack), .irq_nak(irq_nak), .irq_req(irq_req),
        .irq_chan(irq_chan), .prog_start(prog_start), .prog_chan(prog_chan));
    cpis_host i_cpis_host (.sys_clk(sys_clk), .arst_n(arst_n), .irq_req(irq_req),
        .accept(accept), .lag(lag), .irq_ack(irq_ack), .irq_nak(irq_nak));

    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end

    // counts answered offers and program starts seen at the ports
    always @(posedge sys_clk) begin
        if (irq_req === 1'h1 && (irq_ack === 1'h1 || irq_nak === 1'h1)) offers <= offers + 1;
        if (irq_req === 1'h1) last_chan <= irq_chan;
        if (prog_start === 1'h1) begin
            starts <= starts + 1;
            `CHK("prog_chan", 2'h3, prog_chan)
        end
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one apb transfer; pready and read data taken at the rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (pready !== 1'h1) begin
            bad_count++;
            final_report();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        `CHK($sformatf("read %h", a), e, q)
    endtask

    // waits for any offer to be answered, bounded
    task automatic settle;
        int n;
        repeat (3) @(negedge sys_clk);
        n = 0;
        while (irq_req === 1'h1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 50) begin
            bad_count++;
            final_report();
        end
    endtask

    task automatic ev(input cpis_pkg::cpis_evt_e k, input logic [7:0] c);
        @(posedge sys_clk);
        evt <= '{1'h1, k, c};
        @(posedge sys_clk);
        evt <= '0;
        settle();
    endtask

    initial begin
        {arst_n, psel, penable, pwrite, retry_in} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        evt = '0;
        accept = 1'h1;
        lag = 4'h0;
        {bad_count, num_checks, starts, offers} = {4{32'h0}};
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'h1;
        rd(12'h00c, 32'h0);
        rd(12'h040, 32'h0);
        `CHK("unmapped err", 1'h1, err)
        apb(1'h1, 12'h002, 32'h0);
        `CHK("misaligned err", 1'h1, err)
        // plain scan change: flag only, no interrupt
        ev(cpis_pkg::CPIS_EV_SCAN, 8'h00);
        rd(12'h000, 32'h00000800);
        `CHK("offers", 0, offers)
        // block end with flag set
        apb(1'h1, 12'h00c, 32'h00000001);
        ev(cpis_pkg::CPIS_EV_NEXT_BLK, 8'h00);
        `CHK("offers", 1, offers)
        rd(12'h000, 32'h0);
        rd(12'h008, 32'h0000080a);
        rd(12'h004, 32'h0);
        // scan with both enables: interrupt wins, block untouched; slow host
        lag <= 4'h5;
        apb(1'h1, 12'h01c, 32'h00000c00);
        ev(cpis_pkg::CPIS_EV_SCAN, 8'h01);
        rd(12'h010, 32'h00000802);
        rd(12'h014, 32'h0);
        `CHK("starts", 0, starts)
        ev(cpis_pkg::CPIS_EV_PGM_IRQ, 8'h01);
        rd(12'h010, 32'h00000801);
        `CHK("offers", 3, offers)
        // scan with program start only
        apb(1'h1, 12'h03c, 32'h00000800);
        ev(cpis_pkg::CPIS_EV_SCAN, 8'h03);
        `CHK("starts", 1, starts)
        rd(12'h030, 32'h00000800);
        // rejected offers pile up, count stops at three
        lag <= 4'h0;
        accept <= 1'h0;
        repeat (4) ev(cpis_pkg::CPIS_EV_PGM_IRQ, 8'h02);
        rd(12'h02c, 32'h00030000);
        accept <= 1'h1;
        @(posedge sys_clk);
        retry_in <= 1'h1;
        repeat (4) @(posedge sys_clk);
        retry_in <= 1'h0;
        // long margin so a second, wrong pass would show up
        repeat (40) @(negedge sys_clk);
        settle();
        rd(12'h02c, 32'h00020000);
        `CHK("retry chan", 2'h2, last_chan)
        `CHK("offers", 8, offers)
        rd(12'h000, 32'h0);
        final_report();
    end
endmodule // cpis_top_test
